// ===== core/pvo_cfg.svh
// Purpose: constants of the parallel video output port
// Assumes: included by bare name
// Notes:   definitions only
`ifndef PVO_CFG_SVH
`define PVO_CFG_SVH

// Register offsets
`define PVO_REG_MODE      8'h10
`define PVO_REG_OCTL      8'h16
`define PVO_REG_SOFT      8'h1A
`define PVO_REG_STAT      8'h1C
`define PVO_REG_LINE      8'h1E

// Reset values and fields
`define PVO_MODE_RST      16'h0085
`define PVO_OCTL_RST      16'h0000
`define PVO_OCTL_INV      14

// Timing
`define PVO_CLK_NS        50
`define PVO_STRAP_HOLD_NS 50000
`define PVO_STRAP_CYC     ((`PVO_STRAP_HOLD_NS + `PVO_CLK_NS - 1) / `PVO_CLK_NS)
`define PVO_HALF_STD      2'h1
`define PVO_HALF_BYP      2'h2

// 525-line field and blanking boundaries (last line of each span)
`define PVO_N_LINES       10'd525
`define PVO_N_A_END       10'd3
`define PVO_N_B_END       10'd19
`define PVO_N_C_END       10'd263
`define PVO_N_D_END       10'd265
`define PVO_N_E_END       10'd282
`define PVO_N_IMG_FIRST   10'd22
`define PVO_N_IMG_LAST    10'd261
`define PVO_N_FIELD_OFS   10'd263
`define PVO_N_PAD_LINES   10'd3
`define PVO_N_HBLANK      12'd268

// 625-line boundaries
`define PVO_P_LINES       10'd625
`define PVO_P_A_END       10'd22
`define PVO_P_B_END       10'd310
`define PVO_P_C_END       10'd312
`define PVO_P_D_END       10'd335
`define PVO_P_E_END       10'd623
`define PVO_P_HBLANK      12'd280

// Timing reference and blanking codes
`define PVO_TRS_LEN       12'd4
`define PVO_TRS_FF        8'hFF
`define PVO_TRS_00        8'h00
`define PVO_BLK_C         8'h80
`define PVO_BLK_Y         8'h10

`endif

// ===== core/pvo_pkg.sv
// Purpose: shared types of the parallel video output port
// Assumes: nothing
// Notes:   constants live in pvo_cfg.svh
package pvo_pkg;

    typedef enum logic [2:0] {
        FMT_RAW8    = 3'b000,
        FMT_RAW10   = 3'b001,
        FMT_YCC     = 3'b010,
        FMT_RGB565  = 3'b011,
        FMT_RGB555  = 3'b100,
        FMT_RGB444X = 3'b101,
        FMT_RGBX444 = 3'b110
    } pvo_fmt_t;

    typedef enum logic [1:0] {
        ST_STRAP = 2'b00,
        ST_RUN   = 2'b01,
        ST_HALT  = 2'b10
    } pvo_state_t;

    // Raw: y_r = raw[9:2], cb_g[7:6] = raw[1:0]
    typedef struct packed {
        logic [7:0] y_r;
        logic [7:0] cb_g;
        logic [7:0] cr_b;
    } pvo_pix_t;

    typedef struct packed {
        logic [7:0] rsvd;
        logic       en;
        logic       byp;
        logic       pal;
        logic       ovr;
        pvo_fmt_t   fmt;
        logic       il;
    } pvo_mode_t;

endpackage : pvo_pkg

// ===== core/pvo_fmt.sv
// Purpose: packs one pixel into output bytes
// Assumes: phase counts bytes from start of active line
// Notes:   combinational; caller registers the result
`timescale 1ns/1ps
`include "pvo_cfg.svh"
module pvo_fmt
    import pvo_pkg::*;
(
    input  wire pvo_fmt_t   fmt_i,
    input  wire logic [1:0] phase_i,
    input  wire logic       black_i,
    input  wire pvo_pix_t   pix_i,
    output logic [7:0]      byte_o,
    output logic [1:0]      low_o
);
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    logic       sec;

    assign r   = pix_i.y_r;
    assign g   = pix_i.cb_g;
    assign b   = pix_i.cr_b;
    assign sec = phase_i[0];

    always_comb begin
        byte_o = 8'h00;
        low_o  = 2'h0;
        unique case (fmt_i)
            FMT_RAW8: byte_o = r;
            FMT_RAW10: begin
                byte_o = r;
                low_o  = g[7:6];
            end
            FMT_YCC: begin
                if (black_i)
                    byte_o = sec ? `PVO_BLK_Y : `PVO_BLK_C;
                else if (sec)
                    byte_o = r;
                else
                    byte_o = phase_i[1] ? b : g;
            end
            FMT_RGB565:  byte_o = sec ? {g[4:2], b[7:3]} : {r[7:3], g[7:5]};
            FMT_RGB555:  byte_o = sec ? {g[5:3], b[7:3]} : {1'b0, r[7:3], g[7:6]};
            FMT_RGB444X: byte_o = sec ? {b[7:4], 4'h0} : {r[7:4], g[7:4]};
            FMT_RGBX444: byte_o = sec ? {g[7:4], b[7:4]} : {4'h0, r[7:4]};
            default:     byte_o = 8'h00;
        endcase
        if (black_i && fmt_i != FMT_YCC) begin
            byte_o = 8'h00;
            low_o  = 2'h0;
        end
    end
endmodule : pvo_fmt

// ===== core/pvo_port.sv
// Purpose: parallel video output port, progressive and 656 interlaced
// Assumes: ref_clk_i 20 MHz; pixels offered on pix_i, taken on pix_take_o
// Notes:   pixel clock made by divider; pins sampled as straps first
`timescale 1ns/1ps
`include "pvo_cfg.svh"
module pvo_port
    import pvo_pkg::*;
#(
    parameter int H_ACT     = 720,
    parameter int PROG_ROWS = 480,
    parameter int PROG_VBL  = 45,
    parameter int PROG_HBL  = 160
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [15:0]      reg_rdata_o,
    input  wire pvo_pix_t    pix_i,
    output logic             pix_take_o,
    output logic             pixclk_o,
    output logic [7:0]       data_o,
    input  wire logic        low_bit0_strap_pin_i,
    output logic             low_bit0_strap_pin_o,
    output logic             low_bit0_strap_pin_oe_o,
    output logic             low_bit1_out_pin_o,
    input  wire logic        frame_valid_flag_i,
    output logic             frame_valid_flag_o,
    output logic             frame_valid_flag_oe_o,
    input  wire logic        line_valid_flag_i,
    output logic             line_valid_flag_o,
    output logic             line_valid_flag_oe_o,
    output logic             pipe_clk_en_o
);
    localparam logic [11:0] ACT_PIX = 12'(H_ACT);
    localparam logic [9:0]  P_ROWS  = 10'(PROG_ROWS);
    localparam logic [9:0]  P_TOTAL = 10'(PROG_ROWS + PROG_VBL);
    localparam logic [11:0] P_HBL   = 12'(PROG_HBL);
    localparam logic [10:0] STRAP_N = 11'(`PVO_STRAP_CYC);

    function automatic logic [1:0] fv_flags(input logic [9:0] ln, input logic pal);
        if (pal) begin
            if (ln <= `PVO_P_A_END)      fv_flags = 2'b01;
            else if (ln <= `PVO_P_B_END) fv_flags = 2'b00;
            else if (ln <= `PVO_P_C_END) fv_flags = 2'b01;
            else if (ln <= `PVO_P_D_END) fv_flags = 2'b11;
            else if (ln <= `PVO_P_E_END) fv_flags = 2'b10;
            else                         fv_flags = 2'b11;
        end else begin
            if (ln <= `PVO_N_A_END)      fv_flags = 2'b11;
            else if (ln <= `PVO_N_B_END) fv_flags = 2'b01;
            else if (ln <= `PVO_N_C_END) fv_flags = 2'b00;
            else if (ln <= `PVO_N_D_END) fv_flags = 2'b01;
            else if (ln <= `PVO_N_E_END) fv_flags = 2'b11;
            else                         fv_flags = 2'b10;
        end
    endfunction : fv_flags

    function automatic logic [7:0] trs_status(input logic f, input logic v, input logic h);
        trs_status = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction : trs_status

    pvo_state_t  state_reg;
    pvo_mode_t   mode_reg;
    logic [15:0] octl_reg;
    logic        soft_reg;
    logic [15:0] rdata_reg;
    logic [2:0]  sync1_reg;
    logic [2:0]  sync2_reg;
    logic [2:0]  strap_reg;
    logic [10:0] strap_cnt_reg;
    logic [1:0]  half_cnt_reg;
    logic        pclk_reg;
    logic [11:0] h_reg;
    logic [9:0]  v_reg;
    logic [7:0]  data_reg;
    logic [1:0]  low_reg;
    logic        fv_reg;
    logic        lv_reg;
    logic        take_reg;

    logic        run;
    logic        tick;
    logic        pal;
    logic        il;
    logic [1:0]  half_lim;
    logic [11:0] act_bytes;
    logic [11:0] h_total;
    logic [11:0] sav_st;
    logic [11:0] act_st;
    logic [1:0]  flags;
    logic        img;
    logic        pad;
    logic [11:0] ph;
    pvo_fmt_t    fmt_eff;
    logic        black;
    logic [7:0]  fbyte;
    logic [1:0]  flow;
    logic [7:0]  byte_next;
    logic [1:0]  low_next;
    logic        fv_next;
    logic        lv_next;
    logic        take_next;

    assign run  = state_reg == ST_RUN;
    assign il   = mode_reg.il;
    assign pal  = mode_reg.ovr ? mode_reg.pal : strap_reg[0];
    assign half_lim = mode_reg.byp ? `PVO_HALF_BYP : `PVO_HALF_STD;
    assign tick = ce_i && state_reg != ST_STRAP && pclk_reg && half_cnt_reg >= half_lim;
    assign act_bytes = (!il && (mode_reg.fmt == FMT_RAW8 || mode_reg.fmt == FMT_RAW10))
                     ? ACT_PIX : 12'(ACT_PIX << 1);
    assign sav_st  = `PVO_TRS_LEN + (pal ? `PVO_P_HBLANK : `PVO_N_HBLANK);
    assign act_st  = sav_st + `PVO_TRS_LEN;
    assign h_total = il ? 12'(act_st + act_bytes) : 12'(act_bytes + P_HBL);
    assign flags   = fv_flags(v_reg, pal);
    assign ph      = il ? 12'(h_reg - act_st) : h_reg;
    assign fmt_eff = il ? FMT_YCC : mode_reg.fmt;

    always_comb begin
        img = 1'b1;
        pad = 1'b0;
        if (pal) begin
            img = !flags[0];
        end else begin
            img = (v_reg >= `PVO_N_IMG_FIRST && v_reg <= `PVO_N_IMG_LAST)
               || (v_reg >= 10'(`PVO_N_IMG_FIRST + `PVO_N_FIELD_OFS)
                   && v_reg <= 10'(`PVO_N_IMG_LAST + `PVO_N_FIELD_OFS));
            pad = (v_reg > 10'(`PVO_N_IMG_LAST - `PVO_N_PAD_LINES)
                   && v_reg <= `PVO_N_IMG_LAST)
               || (v_reg > 10'(`PVO_N_IMG_LAST + `PVO_N_FIELD_OFS - `PVO_N_PAD_LINES)
                   && v_reg <= 10'(`PVO_N_IMG_LAST + `PVO_N_FIELD_OFS));
        end
    end

    assign black = il && (!img || pad);

    pvo_fmt u_fmt (
        .fmt_i   (fmt_eff),
        .phase_i (ph[1:0]),
        .black_i (black),
        .pix_i   (pix_i),
        .byte_o  (fbyte),
        .low_o   (flow)
    );

    always_comb begin
        byte_next = 8'h00;
        low_next  = 2'h0;
        fv_next   = 1'b0;
        lv_next   = 1'b0;
        take_next = 1'b0;
        if (il) begin
            if (h_reg < `PVO_TRS_LEN || (h_reg >= sav_st && h_reg < act_st)) begin
                unique case (h_reg[1:0])
                    2'h0: byte_next = `PVO_TRS_FF;
                    2'h3: begin
                        byte_next = trs_status(flags[1], flags[0], h_reg < `PVO_TRS_LEN);
                    end
                    default: byte_next = `PVO_TRS_00;
                endcase
            end else if (h_reg < sav_st) begin
                byte_next = h_reg[0] ? `PVO_BLK_Y : `PVO_BLK_C;
            end else begin
                byte_next = fbyte;
                take_next = !black && ph[0];
            end
        end else if (v_reg < P_ROWS) begin
            fv_next = 1'b1;
            if (h_reg < act_bytes) begin
                lv_next   = 1'b1;
                byte_next = fbyte;
                low_next  = flow;
                take_next = ph[0] || fmt_eff == FMT_RAW8 || fmt_eff == FMT_RAW10;
            end
        end
    end

    // Straps and pin synchroniser
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else if (ce_i) begin
            sync1_reg <= {line_valid_flag_i, frame_valid_flag_i, low_bit0_strap_pin_i};
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg     <= ST_STRAP;
            strap_cnt_reg <= 11'h000;
            strap_reg     <= 3'h0;
        end else if (ce_i) begin
            unique case (state_reg)
                ST_STRAP: begin
                    strap_cnt_reg <= strap_cnt_reg + 11'h001;
                    if (strap_cnt_reg >= STRAP_N) begin
                        strap_reg <= sync2_reg;
                        state_reg <= ST_HALT;
                    end
                end
                ST_RUN: if (soft_reg || !mode_reg.en) state_reg <= ST_HALT;
                ST_HALT: if (!soft_reg && mode_reg.en) state_reg <= ST_RUN;
                default: state_reg <= ST_HALT;
            endcase
        end
    end

    // Register file
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg <= `PVO_MODE_RST;
            octl_reg <= `PVO_OCTL_RST;
            soft_reg <= 1'b0;
        end else if (ce_i) begin
            if (reg_wr_i && reg_addr_i == `PVO_REG_SOFT)
                soft_reg <= reg_wdata_i[0];
            if (soft_reg) begin
                mode_reg <= `PVO_MODE_RST;
                octl_reg <= `PVO_OCTL_RST;
            end else if (reg_wr_i && reg_addr_i == `PVO_REG_MODE) begin
                mode_reg <= reg_wdata_i;
            end else if (reg_wr_i && reg_addr_i == `PVO_REG_OCTL) begin
                octl_reg <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= 16'h0000;
        end else if (ce_i) begin
            rdata_reg <= 16'h0000;
            if (reg_rd_i) begin
                unique case (reg_addr_i)
                    `PVO_REG_MODE: rdata_reg <= mode_reg;
                    `PVO_REG_OCTL: rdata_reg <= octl_reg;
                    `PVO_REG_SOFT: rdata_reg <= {15'h0000, soft_reg};
                    `PVO_REG_STAT: rdata_reg <= {11'h000, strap_reg[2:1], flags[1], pal,
                                                 strap_reg[0]};
                    `PVO_REG_LINE: rdata_reg <= {6'h00, v_reg};
                    default:       rdata_reg <= 16'h0000;
                endcase
            end
        end
    end

    // Pixel clock divider
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            half_cnt_reg <= 2'h0;
            pclk_reg     <= 1'b0;
        end else if (ce_i && state_reg != ST_STRAP) begin
            if (half_cnt_reg >= half_lim) begin
                half_cnt_reg <= 2'h1;
                pclk_reg     <= !pclk_reg;
            end else begin
                half_cnt_reg <= half_cnt_reg + 2'h1;
            end
        end
    end

    // Raster counters
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            h_reg <= 12'h000;
            v_reg <= 10'h000;
        end else if (ce_i) begin
            if (!run) begin
                h_reg <= 12'h000;
                v_reg <= il ? 10'h001 : 10'h000;
            end else if (tick) begin
                if (h_reg >= h_total - 12'h001) begin
                    h_reg <= 12'h000;
                    if (il && v_reg >= (pal ? `PVO_P_LINES : `PVO_N_LINES))
                        v_reg <= 10'h001;
                    else if (!il && v_reg >= P_TOTAL - 10'h001)
                        v_reg <= 10'h000;
                    else
                        v_reg <= v_reg + 10'h001;
                end else begin
                    h_reg <= h_reg + 12'h001;
                end
            end
        end
    end

    // Output launch
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            data_reg <= 8'h00;
            low_reg  <= 2'h0;
            fv_reg   <= 1'b0;
            lv_reg   <= 1'b0;
            take_reg <= 1'b0;
        end else if (ce_i) begin
            take_reg <= 1'b0;
            if (!run) begin
                data_reg <= 8'h00;
                low_reg  <= 2'h0;
                fv_reg   <= 1'b0;
                lv_reg   <= 1'b0;
            end else if (tick) begin
                data_reg <= byte_next;
                low_reg  <= low_next;
                fv_reg   <= fv_next;
                lv_reg   <= lv_next;
                take_reg <= take_next;
            end
        end
    end

    assign reg_rdata_o          = rdata_reg;
    assign pix_take_o           = take_reg;
    assign pixclk_o             = pclk_reg ^ octl_reg[`PVO_OCTL_INV];
    assign data_o               = data_reg;
    assign low_bit0_strap_pin_o = low_reg[0];
    assign low_bit1_out_pin_o   = low_reg[1];
    assign frame_valid_flag_o   = fv_reg;
    assign line_valid_flag_o    = lv_reg;
    assign low_bit0_strap_pin_oe_o = state_reg != ST_STRAP;
    assign frame_valid_flag_oe_o   = state_reg != ST_STRAP;
    assign line_valid_flag_oe_o    = state_reg != ST_STRAP;
    assign pipe_clk_en_o        = !mode_reg.byp;

    default clocking dcb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence eav_start_s;
        tick && run && il && h_reg == 12'h000;
    endsequence
    sequence trs_stat_s;
        tick && run && il && h_reg[1:0] == 2'h3
            && (h_reg < `PVO_TRS_LEN || (h_reg >= sav_st && h_reg < act_st));
    endsequence

    pclk_spacing_a: assert property (tick |=> !tick)
        else $error("pixel clock ticks too close");
    eav_first_a: assert property (eav_start_s |=> data_o == `PVO_TRS_FF)
        else $error("timing code does not open with FF");
    h_flag_a: assert property (trs_stat_s |=> data_o[4] == ($past(h_reg) < `PVO_TRS_LEN))
        else $error("wrong H flag in status byte");
    lv_in_fv_a: assert property (line_valid_flag_o |-> frame_valid_flag_o)
        else $error("line valid outside frame valid");
    strap_release_a: assert property (state_reg == ST_STRAP |-> !frame_valid_flag_oe_o
        && !line_valid_flag_oe_o && !low_bit0_strap_pin_oe_o)
        else $error("strap pin driven during sampling");
    soft_default_a: assert property (soft_reg && ce_i |=> mode_reg == `PVO_MODE_RST)
        else $error("soft reset left mode changed");
    raw10_low_a: assert property (tick && run && !il && lv_next && fmt_eff == FMT_RAW10
        |=> low_bit1_out_pin_o == $past(pix_i.cb_g[7]))
        else $error("raw10 low bit lost");
    pclk_pol_a: assert property (tick |=> pixclk_o == octl_reg[`PVO_OCTL_INV])
        else $error("pixel clock level wrong after launch");
endmodule : pvo_port

// ===== tb/pvo_rx_model.sv
// Purpose: capture side of the pixel port
// Assumes: ref_clk_i at twice the pixel clock, or four times in bypass
// Notes:   straps act as pulls on released pins
`timescale 1ns/1ps
module pvo_rx_model (
    input  wire logic        ref_clk_i,
    input  wire logic        inv_i,
    input  wire logic        pixclk_i,
    input  wire logic [7:0]  data_i,
    input  wire logic [2:0]  strap_i,
    input  wire logic [2:0]  pin_o_i,
    input  wire logic [2:0]  pin_oe_i,
    input  wire logic        low1_i,
    output logic      [2:0]  pin_w_o,
    output logic             smp_stb_o,
    output logic      [11:0] smp_o
);
    logic pclk_q;
    assign pin_w_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & strap_i);
    always_ff @(posedge ref_clk_i) begin
        pclk_q    <= pixclk_i;
        smp_stb_o <= (pixclk_i != pclk_q) && (pixclk_i == !inv_i);
        smp_o     <= {low1_i, pin_w_o[2:1], pin_w_o[0], data_i};
    end
endmodule : pvo_rx_model

// ===== tb/pvo_port_tb.sv
// Purpose: self-checking bench of the pixel port
// Assumes: short lines and frames through parameters
// Notes:   first interlaced line after run is line 1
`timescale 1ns/1ps
`include "pvo_cfg.svh"
`define TB_CHK(a_, b_) begin comparisons++; if ((a_) !== (b_)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a_), (b_)); end end
module pvo_port_tb
    import pvo_pkg::*;
;
    logic        ref_clk_i = 0, rst_i = 1, inv = 0, rd_seen = 0, armed = 0, il_chk = 0;
    logic        sav = 0, hexp = 1, seen = 0, pal = 0, r10 = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic [7:0]  reg_addr_i = 0, data_o, dq;
    logic [15:0] reg_wdata_i = 0, reg_rdata_o;
    logic [2:0]  strap = 0, pin_o, pin_oe, pin_w;
    logic        pixclk_o, pix_take_o, pipe_clk_en_o, low1, smp_stb;
    logic [11:0] smp;
    logic [23:0] hst = 0;
    logic [9:0]  e, q[$];
    logic [31:0] rnd = 32'h6082, e32, rd_q[$];
    pvo_pix_t    pix = 24'h557733;
    logic [15:0] tbl [9] = '{16'h80, 16'h82, 16'h84, 16'h86, 16'h88, 16'h8A, 16'h8C, 16'hC0, 16'h84};
    int          err_count = 0, comparisons = 0, cyc = 0, ln = 0, gap = 0, exp_gap = 2;
    int          takes = 0;

    pvo_port #(.H_ACT(4), .PROG_ROWS(2), .PROG_VBL(1), .PROG_HBL(2)) pvo_port_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .pix_i(pix), .pix_take_o(pix_take_o), .pixclk_o(pixclk_o),
        .data_o(data_o), .low_bit0_strap_pin_i(pin_w[0]), .low_bit0_strap_pin_o(pin_o[0]),
        .low_bit0_strap_pin_oe_o(pin_oe[0]), .low_bit1_out_pin_o(low1),
        .frame_valid_flag_i(pin_w[1]), .frame_valid_flag_o(pin_o[1]),
        .frame_valid_flag_oe_o(pin_oe[1]), .line_valid_flag_i(pin_w[2]),
        .line_valid_flag_o(pin_o[2]), .line_valid_flag_oe_o(pin_oe[2]),
        .pipe_clk_en_o(pipe_clk_en_o));
    pvo_rx_model pvo_rx_model_inst (.ref_clk_i(ref_clk_i), .inv_i(inv), .pixclk_i(pixclk_o),
        .data_i(data_o), .strap_i(strap), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .low1_i(low1),
        .pin_w_o(pin_w), .smp_stb_o(smp_stb), .smp_o(smp));

    initial begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [7:0] stat(input int l, input logic p, input logic h);
        logic f, v;
        f = p ? l >= 313 : (l <= 3 || l >= 266);
        v = p ? (l <= 22 || (l >= 311 && l <= 335) || l >= 624) : (l <= 19 || (l >= 264 && l <= 282));
        return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction : stat

    function automatic logic img(input int l, input logic p);
        return p ? ((l >= 23 && l <= 310) || (l >= 336 && l <= 623))
                 : ((l >= 22 && l <= 258) || (l >= 285 && l <= 521));
    endfunction : img

    function automatic logic [9:0] pbyte(input logic [2:0] f, input int k, input pvo_pix_t p);
        case (f)
            3'd0: return {2'b00, p.y_r};
            3'd1: return {p.cb_g[7:6], p.y_r};
            3'd2: return {2'b00, k[0] ? p.y_r : (k[1] ? p.cr_b : p.cb_g)};
            3'd3: return {2'b00, k[0] ? {p.cb_g[4:2], p.cr_b[7:3]} : {p.y_r[7:3], p.cb_g[7:5]}};
            3'd4: return {2'b00, k[0] ? {p.cb_g[5:3], p.cr_b[7:3]}
                                      : {1'b0, p.y_r[7:3], p.cb_g[7:6]}};
            3'd5: return {2'b00, k[0] ? {p.cr_b[7:4], 4'h0} : {p.y_r[7:4], p.cb_g[7:4]}};
            default: return {2'b00, k[0] ? {p.cb_g[7:4], p.cr_b[7:4]} : {4'h0, p.y_r[7:4]}};
        endcase
    endfunction : pbyte

    task automatic complete_run;
        $display("err_count=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] x);
        @(posedge ref_clk_i);
        rd_q.push_back({m, x});
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
    endtask : rd

    task automatic do_reset(input logic [15:0] sx);
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        {ln, hst, sav, hexp, il_chk} = {32'd0, 24'h0, 3'b011};
        rst_i <= 1'b0;
        rd(`PVO_REG_MODE, 16'hFFFF, `PVO_MODE_RST);
        rd(`PVO_REG_OCTL, 16'hFFFF, `PVO_OCTL_RST);
        rd(8'h02, 16'hFFFF, 16'h0000);
        for (int k = 0; k < 30000 && ln < 30; k++) @(posedge ref_clk_i);
        `TB_CHK(ln >= 30, 1'b1)
        il_chk = 0;
        rd(`PVO_REG_STAT, 16'h001B, sx);
    endtask : do_reset

    task automatic run_pg(input logic [15:0] m);
        rnd = lfsr(rnd);
        pix <= rnd[23:0];
        r10 = m[3:1] == 3'd1;
        exp_gap = m[6] ? 4 : 2;
        wr(`PVO_REG_MODE, m);
        repeat (60) @(posedge ref_clk_i);
        `TB_CHK(pipe_clk_en_o, !m[6])
        for (int k = 0; k < 200 && pin_w[1] !== 1'b0; k++) @(posedge ref_clk_i);
        for (int k = 0; k < (m[3:1] < 3'd2 ? 4 : 8); k++) q.push_back(pbyte(m[3:1], k, pix));
        takes = 0;
        armed <= 1'b1;
        @(posedge ref_clk_i);
        for (int k = 0; k < 400 && armed; k++) @(posedge ref_clk_i);
        `TB_CHK(armed, 1'b0)
        armed = 0;
        q.delete();
    endtask : run_pg

    always @(posedge ref_clk_i) begin
        rd_seen <= reg_rd_i;
        if (rd_seen) begin
            e32 = rd_q.pop_front();
            `TB_CHK(reg_rdata_o & e32[31:16], e32[15:0])
        end
        gap++;
        if (armed && pix_take_o === 1'b1) takes++;
        if (smp_stb === 1'b1) begin
            if (il_chk) begin
                if (sav) `TB_CHK(smp[7:0], img(ln, pal) ? pix.cb_g : 8'h80)
                sav = 0;
                if (hst == 24'hFF0000) begin
                    ln += hexp;
                    `TB_CHK({smp[10:9], smp[7:0]}, {2'b00, stat(ln, pal, hexp)})
                    sav = !hexp;
                    hexp = !hexp;
                end
                hst = {hst[15:0], smp[7:0]};
            end
            if (armed) begin
                `TB_CHK(gap, exp_gap)
                if (smp[10]) begin
                    e = q.size() ? q.pop_front() : 10'hx;
                    `TB_CHK({smp[9], r10 ? {smp[11], smp[8]} : 2'b00, smp[7:0]}, {1'b1, e})
                    seen = 1;
                end else if (seen) begin
                    `TB_CHK(q.size(), 0)
                    `TB_CHK(takes, 4)
                    {armed, seen} = 2'b00;
                end
            end
            gap = 0;
        end
        if (armed && data_o !== dq) `TB_CHK(pixclk_o, inv)
        dq = data_o;
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            complete_run();
        end
    end

    initial begin
        strap = 3'b011;
        pal = 1;
        do_reset(16'h000B);
        strap = 3'b100;
        pal = 0;
        do_reset(16'h0010);
        wr(`PVO_REG_MODE, 16'h00B5);
        rd(`PVO_REG_STAT, 16'h0002, 16'h0002);
        for (int i = 0; i < 9; i++) begin
            if (i == 8) begin
                wr(`PVO_REG_OCTL, 16'h4000);
                inv = 1;
                rd(`PVO_REG_OCTL, 16'hFFFF, 16'h4000);
            end
            run_pg(tbl[i]);
        end
        wr(`PVO_REG_SOFT, 16'h0001);
        rd(`PVO_REG_MODE, 16'hFFFF, `PVO_MODE_RST);
        rd(`PVO_REG_OCTL, 16'hFFFF, `PVO_OCTL_RST);
        wr(`PVO_REG_MODE, 16'h0088);
        rd(`PVO_REG_MODE, 16'hFFFF, `PVO_MODE_RST);
        wr(`PVO_REG_SOFT, 16'h0000);
        wr(`PVO_REG_MODE, 16'h0088);
        rd(`PVO_REG_MODE, 16'hFFFF, 16'h0088);
        repeat (3) @(posedge ref_clk_i);
        complete_run();
    end
endmodule : pvo_port_tb
